// ### torque_limit_regs.svh
// Constants for the torque limit selector
`ifndef TORQUE_LIMIT_REGS_SVH
`define TORQUE_LIMIT_REGS_SVH
`define TL_PCT_MAX 10'h320
`define TL_INT_RST 10'h320
`define TL_EXT_RST 10'h064
`define TL_SEL_RST 16'h0000
`define TL_ROUTE_LSB 0
`define TL_ROUTE_W 4
`define TL_MON_FWD_POS 6
`define TL_MON_REV_POS 7
`endif

// ### torque_limit_pkg.sv
// Types for the torque limit selector
`default_nettype none
package torque_limit_pkg;
  typedef logic [9:0] pct_t;
  typedef struct packed {
    logic [9:0] fwd_internal_limit;
    logic [9:0] rev_internal_limit;
    logic [9:0] fwd_external_limit;
    logic [9:0] rev_external_limit;
  } limit_set_s;
  typedef enum logic [1:0] {
    DIR_FWD = 2'h1,
    DIR_REV = 2'h2
  } dir_e;
endpackage
`default_nettype wire

// ### limit_input_sync.sv
// Three-stage synchroniser with agreement filter for contact inputs
`default_nettype none
module limit_input_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk, // Drive clock
  input wire logic arst_n, // Async reset, active low
  input wire logic clk_en, // Clock enable
  input wire logic [WIDTH-1:0] pin_in, // Raw pins
  output logic [WIDTH-1:0] level_q // Filtered level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Per bit: three flops, accept once stages two and three agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        s1_q[i] <= 1'b1;
        s2_q[i] <= 1'b1;
        s3_q[i] <= 1'b1;
        level_q[i] <= 1'b1;
      end else if (clk_en) begin
        s1_q[i] <= pin_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### torque_limit_selector.sv
// Torque limit selection, comparison and limit flag routing
`include "torque_limit_regs.svh"
`default_nettype none
module torque_limit_selector (
  input wire logic ref_clk, // Drive clock, 20 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic clk_en, // Freezes state when low
  input wire logic cfg_we, // Load limit set and select word
  input wire torque_limit_pkg::limit_set_s cfg_limits, // New limit set
  input wire logic [15:0] cfg_select, // New output select word two
  input wire logic [9:0] motor_max_torque, // Motor maximum, percent
  input wire logic [10:0] torque_ref, // Signed torque reference, percent
  input wire logic fwd_external_limit_in_n, // Forward external pin, low active
  input wire logic rev_external_limit_in_n, // Reverse external pin, low active
  input wire logic [2:0] other_out_sig, // Other signals routed to circuits 1-3
  output logic [2:0] output_circuit_n_q, // Output circuits 1-3, low when closed
  output logic limit_active_flag_q, // Torque limiting now
  output logic [9:0] active_limit_q, // Active limit, percent
  output logic [7:0] io_state_monitor_q, // Input monitor positions
  output logic [2:0] output_signal_monitor_q, // Output monitor
  output torque_limit_pkg::limit_set_s limits_q, // Stored limit set
  output logic [15:0] output_select_word_two_q // Stored select word
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [1:0] ext_n;
  logic [10:0] ref_mag;
  logic ref_neg;
  logic [9:0] fwd_lim;
  logic [9:0] rev_lim;
  logic [9:0] lim_d;
  logic [3:0] route;
  logic [2:0] circ_d;

  limit_input_sync #(.WIDTH(2)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pin_in({rev_external_limit_in_n, fwd_external_limit_in_n}),
    .level_q(ext_n)
  );

  // ----------------------------------------
  // Settings store
  // ----------------------------------------
  // Clip a setting into the 0..800 range
  function automatic logic [9:0] sat_pct(input logic [9:0] v);
    sat_pct = (v > `TL_PCT_MAX) ? `TL_PCT_MAX : v;
  endfunction

  // Load settings, each limit held within 0..800
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      limits_q.fwd_internal_limit <= `TL_INT_RST;
      limits_q.rev_internal_limit <= `TL_INT_RST;
      limits_q.fwd_external_limit <= `TL_EXT_RST;
      limits_q.rev_external_limit <= `TL_EXT_RST;
      output_select_word_two_q <= `TL_SEL_RST;
    end else if (clk_en && cfg_we) begin
      limits_q.fwd_internal_limit <= sat_pct(cfg_limits.fwd_internal_limit);
      limits_q.rev_internal_limit <= sat_pct(cfg_limits.rev_internal_limit);
      limits_q.fwd_external_limit <= sat_pct(cfg_limits.fwd_external_limit);
      limits_q.rev_external_limit <= sat_pct(cfg_limits.rev_external_limit);
      output_select_word_two_q <= cfg_select;
    end
  end

  // ----------------------------------------
  // Limit selection and comparison
  // ----------------------------------------
  // Pick per-direction limit, then clamp to motor maximum
  always_comb begin
    ref_neg = torque_ref[10];
    ref_mag = ref_neg ? (11'h000 - torque_ref) : torque_ref;
    fwd_lim = limits_q.fwd_internal_limit;
    rev_lim = limits_q.rev_internal_limit;
    if (!ext_n[0] && limits_q.fwd_external_limit < fwd_lim) begin
      fwd_lim = limits_q.fwd_external_limit;
    end
    if (!ext_n[1] && limits_q.rev_external_limit < rev_lim) begin
      rev_lim = limits_q.rev_external_limit;
    end
    lim_d = ref_neg ? rev_lim : fwd_lim;
    if (lim_d > motor_max_torque) begin
      lim_d = motor_max_torque;
    end
  end

  // Limit flag and active limit register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      limit_active_flag_q <= 1'b0;
      active_limit_q <= `TL_INT_RST;
    end else if (clk_en) begin
      limit_active_flag_q <= (ref_mag > {1'b0, lim_d});
      active_limit_q <= lim_d;
    end
  end

  // ----------------------------------------
  // Output routing and monitors
  // ----------------------------------------
  // Each circuit ORs other signals with the flag when routed to it
  always_comb begin
    route = output_select_word_two_q[`TL_ROUTE_LSB +: `TL_ROUTE_W];
    circ_d = other_out_sig;
    for (int i = 0; i < 3; i++) begin
      if (route == 4'(i + 1) && limit_active_flag_q) begin
        circ_d[i] = 1'b1;
      end
    end
  end

  // Drive circuits low when closed, and update monitors
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      output_circuit_n_q <= 3'h7;
      output_signal_monitor_q <= 3'h0;
      io_state_monitor_q <= 8'h00;
    end else if (clk_en) begin
      output_circuit_n_q <= ~circ_d;
      output_signal_monitor_q <= circ_d;
      io_state_monitor_q <= 8'h00;
      io_state_monitor_q[`TL_MON_FWD_POS] <= ~ext_n[0];
      io_state_monitor_q[`TL_MON_REV_POS] <= ~ext_n[1];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Flag against the active limit, one cycle after the compare
  flag_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && ref_mag > {1'b0, lim_d} |=> limit_active_flag_q)
    else $error("limit flag not set");
  flag_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && ref_mag < {1'b0, lim_d} |=> !limit_active_flag_q)
    else $error("limit flag not cleared");

  // Active limit stays under the motor maximum and the limits of its direction, external ones only with the contact closed
  clamp_max_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en |=> active_limit_q <= $past(motor_max_torque))
    else $error("limit above motor maximum");
  int_fwd_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && !ref_neg |=> active_limit_q <= $past(limits_q.fwd_internal_limit))
    else $error("forward internal limit exceeded");
  int_rev_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && ref_neg |=> active_limit_q <= $past(limits_q.rev_internal_limit))
    else $error("reverse internal limit exceeded");
  fwd_ext_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && !ext_n[0] && !ref_neg
    |=> active_limit_q <= $past(limits_q.fwd_external_limit))
    else $error("forward external limit not applied");
  rev_ext_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && !ext_n[1] && ref_neg
    |=> active_limit_q <= $past(limits_q.rev_external_limit))
    else $error("reverse external limit not applied");

  // Stored limits stay inside 0..800
  int_range_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    limits_q.fwd_internal_limit <= 10'h320 && limits_q.rev_internal_limit <= 10'h320)
    else $error("internal limit out of range");
  ext_range_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    limits_q.fwd_external_limit <= 10'h320 && limits_q.rev_external_limit <= 10'h320)
    else $error("external limit out of range");

  // Routing of the flag and of the other signals to the circuits
  route_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && limit_active_flag_q && route == 4'h2 |=> !output_circuit_n_q[1])
    else $error("routed circuit not closed");
  route1_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && limit_active_flag_q && route == 4'h1 |=> !output_circuit_n_q[0])
    else $error("circuit one not closed");
  route3_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && limit_active_flag_q && route == 4'h3 |=> !output_circuit_n_q[2])
    else $error("circuit three not closed");
  no_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && route == 4'h0 |=> output_signal_monitor_q == $past(other_out_sig))
    else $error("flag routed while disabled");
  off_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && (route == 4'h0 || route > 4'h3)
    |=> output_circuit_n_q == ~$past(other_out_sig))
    else $error("flag routed to no valid circuit");
  or_other_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en |=> (~output_circuit_n_q & $past(other_out_sig)) == $past(other_out_sig))
    else $error("other signal lost on circuit");

  // Input monitor follows the filtered contacts
  mon_in_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en |=> io_state_monitor_q[7:6] == ~$past(ext_n))
    else $error("input monitor mismatch");
  // Clock enable low holds the flag, active limit, circuits, stored limits and filtered inputs
  freeze_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !clk_en |=> $stable(limit_active_flag_q) && $stable(active_limit_q)
    && $stable(output_circuit_n_q) && $stable(limits_q) && $stable(ext_n))
    else $error("state moved while frozen");

  // ----------------------------------------
  // Scenario covers
  // ----------------------------------------
  limiting_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    limit_active_flag_q);
  ext_fwd_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    !ext_n[0] && limit_active_flag_q);
  ext_rev_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    !ext_n[1] && ref_neg && limit_active_flag_q);
  route1_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    route == 4'h1 && !output_circuit_n_q[0]);
  route3_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    route == 4'h3 && !output_circuit_n_q[2]);
endmodule
`default_nettype wire

// ### limit_contact_host.sv
// Host-side contact drivers for the external limit pins
`default_nettype none
module limit_contact_host (
  input wire logic ref_clk, // Drive clock
  input wire logic fwd_on, // Close forward contact
  input wire logic rev_on, // Close reverse contact
  output logic fwd_pin_n, // Forward contact, low when closed
  output logic rev_pin_n // Reverse contact, low when closed
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contacts open (high) until first request
  initial begin
    fwd_pin_n = 1'b1;
    rev_pin_n = 1'b1;
  end
  // Closed contact pulls low, open reads high
  always @(posedge ref_clk) begin
    fwd_pin_n <= ~fwd_on;
    rev_pin_n <= ~rev_on;
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the torque limit selector
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {time at; logic [2:0] c; logic f; logic [9:0] a; logic [7:0] io;
    logic [39:0] l; logic [15:0] s;} note_s;
  logic ref_clk = 0, arst_n = 0, cfg_we = 0, fwd_on = 0, rev_on = 0, fwd_n, rev_n, flag;
  logic clk_en = 1;
  torque_limit_pkg::limit_set_s cfg_limits = '0, lims;
  logic [15:0] cfg_sel = '0, sel;
  logic [9:0] mmax = 10'h3ff, lim;
  logic [10:0] tref = '0;
  logic [2:0] other = '0, circ_n, omon;
  logic [7:0] io;
  int mismatches = 0, check_count = 0;
  note_s q[$], n;
  limit_contact_host limit_contact_host_inst (.ref_clk(ref_clk), .fwd_on(fwd_on),
    .rev_on(rev_on), .fwd_pin_n(fwd_n), .rev_pin_n(rev_n));
  torque_limit_selector torque_limit_selector_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .clk_en(clk_en), .cfg_we(cfg_we), .cfg_limits(cfg_limits), .cfg_select(cfg_sel),
    .motor_max_torque(mmax), .torque_ref(tref), .fwd_external_limit_in_n(fwd_n),
    .rev_external_limit_in_n(rev_n), .other_out_sig(other), .output_circuit_n_q(circ_n),
    .limit_active_flag_q(flag), .active_limit_q(lim), .io_state_monitor_q(io),
    .output_signal_monitor_q(omon), .limits_q(lims), .output_select_word_two_q(sel));
  // Clock, 50 ns period
  initial forever #25 ref_clk = ~ref_clk;
  task automatic cmp(string nm, logic [39:0] e, logic [39:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [9:0] sat(logic [9:0] v);
    return (v > 10'h320) ? 10'h320 : v;
  endfunction
  // Watcher: compare oldest note once its settle time is reached
  always @(posedge ref_clk) begin
    if (q.size() != 0 && $time >= q[0].at) begin
      n = q.pop_front();
      cmp("circuits", n.c, circ_n);
      cmp("flag", n.f, flag);
      cmp("active_limit", n.a, lim);
      cmp("io_monitor", n.io, io);
      cmp("out_monitor", 3'(~n.c), omon);
      cmp("limits", n.l, lims);
      cmp("select", n.s, sel);
    end
  end
  // Driver: reset, then random settings held until outputs settle
  initial begin
    torque_limit_pkg::limit_set_s l;
    logic [9:0] m, a, mag;
    logic [3:0] r;
    logic [2:0] o, act;
    logic f, rv, ng;
    void'($urandom(32'heb0b3b76));
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    q.push_back('{$time + 100, 3'h7, 1'b0, 10'h320, 8'h00, 40'hc832019064, 16'h0000});
    for (int i = 0; i < 60; i++) begin
      l = 40'({$urandom(), $urandom()});
      m = 10'($urandom());
      r = 4'($urandom_range(5));
      o = 3'($urandom());
      f = 1'($urandom());
      rv = 1'($urandom());
      ng = 1'($urandom());
      a = ng ? sat(l.rev_internal_limit) : sat(l.fwd_internal_limit);
      if (ng && rv && sat(l.rev_external_limit) < a) a = sat(l.rev_external_limit);
      if (!ng && f && sat(l.fwd_external_limit) < a) a = sat(l.fwd_external_limit);
      if (a > m) a = m;
      mag = (i % 3 == 0) ? a : 10'($urandom());
      if (i % 3 == 1 && a != 10'h3ff) mag = a + 10'h001;
      if (mag == 10'h000) mag = 10'h001;
      act = o | ((mag > a && r >= 1 && r <= 3) ? 3'(1 << (r - 1)) : 3'h0);
      @(posedge ref_clk);
      cfg_limits <= l;
      cfg_sel <= {12'($urandom()), r};
      mmax <= m;
      tref <= ng ? -{1'b0, mag} : {1'b0, mag};
      other <= o;
      fwd_on <= f;
      rev_on <= rv;
      cfg_we <= 1'b1;
      #1 q.push_back('{$time + 599, ~act, mag > a, a, {rv, f, 6'h00},
        {sat(l[39:30]), sat(l[29:20]), sat(l[19:10]), sat(l[9:0])}, cfg_sel});
      @(posedge ref_clk);
      cfg_we <= 1'b0;
      @(posedge ref_clk);
      clk_en <= 1'($urandom()); // Random one-cycle freeze after the load
      @(posedge ref_clk);
      clk_en <= 1'b1;
      repeat (8) @(posedge ref_clk);
    end
    for (int k = 0; k < 100 && q.size() != 0; k++) @(posedge ref_clk);
    if (q.size() != 0) mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
